// [src/gep_pkg.sv]
// package: constants, carriers and register map of the gesture event port
// Function
// - map each event to one of five pins
// - six selectable pin actions incl 100 ms pulse
// - five electrodes tracked as independent zones
// - touch flag; short or long by duration
// - tap only if release within tap delay
// - double tap: two taps within interval
// - circle held until movement ends, with direction
// - wheel counter up cw, down ccw
// - position samples at 200 per second
// - self wake-up alternates sleep and scan
// - approach scan interval, channel mask selectable
// - threshold exceeded: leave to processing, tell host
// - calibration scans with all five channels
// - calibration spacing up to 2047 s
// - start interval until timeout, then final
`default_nettype none
package gep_pkg;
  localparam int NPIN = 5; // event pins
  localparam int NCH = 5; // electrodes / rx channels
  localparam int NEV = 8; // event sources
  // timing
  localparam int CLK_NS = 8; // pclk period
  localparam int MS_NS = 1000000; // one millisecond
  localparam int MS_CYC = MS_NS / CLK_NS; // cycles per ms tick
  localparam int SEC_MS = 1000; // ms per second tick
  localparam int PULSE_MS = 100; // pin pulse length
  localparam int POS_MS = 5; // 200 samples per second
  localparam int SCAN_CYC = 8; // cycles one scan lasts
  // event numbers, also status bit positions
  localparam int EV_TAP = 0;
  localparam int EV_DTAP = 1;
  localparam int EV_SHORT = 2;
  localparam int EV_LONG = 3;
  localparam int EV_TOUCH = 4;
  localparam int EV_CW = 5;
  localparam int EV_CCW = 6;
  localparam int EV_APPR = 7;
  // pin actions
  localparam logic [2:0] ACT_HI = 3'h0;
  localparam logic [2:0] ACT_LO = 3'h1;
  localparam logic [2:0] ACT_TOG = 3'h2;
  localparam logic [2:0] ACT_PLS = 3'h3;
  localparam logic [2:0] ACT_LVH = 3'h4;
  localparam logic [2:0] ACT_LVL = 3'h5;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_MAP0 = 8'h0C;
  localparam logic [7:0] OFF_MAP1 = 8'h10;
  localparam logic [7:0] OFF_TAP = 8'h14;
  localparam logic [7:0] OFF_TOUCH = 8'h18;
  localparam logic [7:0] OFF_SCAN = 8'h1C;
  localparam logic [7:0] OFF_CAL = 8'h20;
  localparam logic [7:0] OFF_WHEEL = 8'h24;
  // reset values
  localparam logic [31:0] RST_MAP = 32'hFFFFFFFF; // pin 7 = unmapped
  localparam logic [9:0] RST_TAP_MS = 10'h1F4;
  localparam logic [9:0] RST_DTAP_MS = 10'h1F4;
  localparam logic [9:0] RST_LONG_MS = 10'h1F4;
  localparam logic [7:0] RST_APP_MS = 8'h14;
  localparam logic [4:0] RST_CHMSK = 5'h01;
  localparam logic [11:0] RST_THR = 12'h040;
  localparam logic [10:0] RST_CAL_ST = 11'h002;
  localparam logic [10:0] RST_CAL_FIN = 11'h00A;
  localparam logic [9:0] RST_TRANS = 10'h078;
  // core side carrier
  typedef struct packed {
    logic [NCH-1:0] touch; // electrode touched
    logic circ_det; // circle recognised
    logic circ_cw; // its direction
    logic circ_end; // hand stopped or left
    logic whl_step; // one wheel step
    logic whl_cw; // its direction
  } gep_core_t;
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } gep_pos_t;
  typedef enum logic [3:0] {
    ST_PROC = 4'h1,
    ST_SLEEP = 4'h2,
    ST_APP = 4'h4,
    ST_CAL = 4'h8
  } gep_st_e_t;
endpackage
`default_nettype wire

// [src/gep_pin.sv]
// one event output pin with its action engine
`default_nettype none
module gep_pin
  import gep_pkg::*;
#(
  parameter int PLS_MS = PULSE_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ms_tk,
  input wire logic set_hi,
  input wire logic set_lo,
  input wire logic tog,
  input wire logic pls,
  input wire logic lvl_en,
  input wire logic lvl,
  output logic pin
);
  typedef struct packed {
    logic out; // pin level
    logic [6:0] pcnt; // pulse ms left
  } gep_pin_st_t;
  gep_pin_st_t s_reg, s_next;

  // level modes win; otherwise edge actions, pulse times out on ms ticks
  always_comb begin
    s_next = s_reg;
    if (s_reg.pcnt != 7'h00 && ms_tk) begin
      s_next.pcnt = s_reg.pcnt - 7'h01;
      if (s_reg.pcnt == 7'h01) begin
        s_next.out = 1'b0;
      end
    end
    if (lvl_en) begin
      s_next.out = lvl;
      s_next.pcnt = 7'h00;
    end else if (pls) begin
      s_next.out = 1'b1;
      s_next.pcnt = 7'(PLS_MS);
    end else if (set_hi) begin
      s_next.out = 1'b1;
    end else if (set_lo) begin
      s_next.out = 1'b0;
    end else if (tog) begin
      s_next.out = ~s_reg.out;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pin = s_reg.out;
endmodule
`default_nettype wire

// [src/gep_top.sv]
// event port, tap qualifier, wheel counter and wake scan scheduler
//
// Register access over APB and the address map were decided locally.
`default_nettype none
module gep_top #(
  parameter int MS_DIV = gep_pkg::MS_CYC // cycles per ms tick
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gep_pkg::gep_core_t core,
  input wire gep_pkg::gep_pos_t pos_in,
  input wire logic [4:0][11:0] ch_delta,
  output logic [4:0] event_output_pin,
  output gep_pkg::gep_pos_t pos_out,
  output logic pos_stb,
  output logic [4:0] rx_en,
  output logic proc_mode,
  output logic irq
);
  import gep_pkg::*;

  // whole block state
  typedef struct packed {
    logic [19:0] ms_div; // clock prescaler
    logic ms_tk; // ms tick
    logic [9:0] sec_div; // ms to s
    logic sec_tk; // second tick
    logic [7:0] stat; // sticky events
    logic [7:0] mask; // irq enables
    logic [31:0] map0; // events 0..3
    logic [31:0] map1; // events 4..7
    logic [9:0] tap_ms; // single tap delay
    logic [9:0] dtap_ms; // double tap interval
    logic [9:0] long_ms; // long touch limit
    logic [7:0] app_ms; // approach interval
    logic [4:0] chmsk; // monitored channels
    logic [11:0] thr; // wake threshold
    logic [10:0] cal_st; // start interval s
    logic [10:0] cal_fin; // final interval s
    logic [9:0] trans; // inactivity timeout s
    logic [4:0] tprev; // touch last cycle
    logic [4:0][9:0] dur; // touch length ms
    logic [4:0][9:0] dwin; // since first tap
    logic [4:0] dwarm; // first tap seen
    logic cpend; // circle waiting
    logic ccw_dir; // its direction
    logic [15:0] wheel; // rotation count
    gep_st_e_t st; // wake scheduler
    logic [7:0] app_cnt; // ms in sleep
    logic [10:0] cal_cnt; // s since calibration
    logic [9:0] inact; // s inactive
    logic fin_sel; // final interval in use
    logic [3:0] scn; // scan cycle
    logic [4:0] rx_en; // channel enables
    logic [2:0] pos_cnt; // ms since last sample
    logic pos_stb; // sample strobe
    gep_pos_t pos; // last sample
    logic irq; // interrupt
    logic [31:0] prdata; // read data
    logic pready; // access done
    logic pslverr; // unmapped
  } gep_top_st_t;

  gep_top_st_t s_reg, s_next;
  logic [NEV-1:0] ev; // event pulses
  logic [NEV-1:0] lev; // event levels
  logic [NPIN-1:0] p_hi, p_lo, p_tog, p_pls, p_len, p_lvl;

  // event sources, prescaler, touch, wheel, scheduler and bus
  always_comb begin
    logic over;
    logic [10:0] cal_lim;
    logic wr, rd;
    s_next = s_reg;
    ev = '0;
    over = 1'b0;
    cal_lim = '0;
    wr = psel && penable && s_reg.pready && pwrite;
    rd = psel && penable && s_reg.pready && !pwrite;
    // ms and s ticks
    s_next.ms_tk = 1'b0;
    s_next.sec_tk = 1'b0;
    if (s_reg.ms_div == 20'(MS_DIV - 1)) begin
      s_next.ms_div = '0;
      s_next.ms_tk = 1'b1;
    end else begin
      s_next.ms_div = s_reg.ms_div + 20'h00001;
    end
    if (s_reg.ms_tk) begin
      if (s_reg.sec_div == 10'(SEC_MS - 1)) begin
        s_next.sec_div = '0;
        s_next.sec_tk = 1'b1;
      end else begin
        s_next.sec_div = s_reg.sec_div + 10'h001;
      end
    end
    // per electrode zone
    s_next.tprev = core.touch;
    for (int i = 0; i < NCH; i++) begin
      // touch start restarts the length count
      if (core.touch[i] && !s_reg.tprev[i]) begin
        s_next.dur[i] = '0;
        ev[EV_TOUCH] = 1'b1;
      end else if (core.touch[i] && s_reg.ms_tk && s_reg.dur[i] != 10'h3FF) begin
        s_next.dur[i] = s_reg.dur[i] + 10'h001;
      end
      // double tap window ages out
      if (s_reg.dwarm[i] && s_reg.ms_tk) begin
        s_next.dwin[i] = s_reg.dwin[i] + 10'h001;
        if (s_reg.dwin[i] >= s_reg.dtap_ms) begin
          s_next.dwarm[i] = 1'b0;
        end
      end
      // release classifies the touch
      if (!core.touch[i] && s_reg.tprev[i]) begin
        if (s_reg.dur[i] >= s_reg.long_ms) begin
          ev[EV_LONG] = 1'b1;
        end else begin
          ev[EV_SHORT] = 1'b1;
        end
        if (s_reg.dur[i] < s_reg.tap_ms) begin
          ev[EV_TAP] = 1'b1;
          if (s_reg.dwarm[i] && s_reg.dwin[i] < s_reg.dtap_ms) begin
            ev[EV_DTAP] = 1'b1;
            s_next.dwarm[i] = 1'b0;
          end else begin
            s_next.dwarm[i] = 1'b1;
            s_next.dwin[i] = '0;
          end
        end
      end
    end
    // circle is held back until the hand stops or leaves
    if (core.circ_det) begin
      s_next.cpend = 1'b1;
      s_next.ccw_dir = ~core.circ_cw;
    end else if (s_reg.cpend && core.circ_end) begin
      s_next.cpend = 1'b0;
      ev[EV_CW] = ~s_reg.ccw_dir;
      ev[EV_CCW] = s_reg.ccw_dir;
    end
    // wheel steps
    if (core.whl_step) begin
      if (core.whl_cw) begin
        s_next.wheel = s_reg.wheel + 16'h0001;
      end else begin
        s_next.wheel = s_reg.wheel - 16'h0001;
      end
    end
    // position sampling only while processing
    s_next.pos_stb = 1'b0;
    if (s_reg.st == ST_PROC && s_reg.ms_tk) begin
      if (s_reg.pos_cnt == 3'(POS_MS - 1)) begin
        s_next.pos_cnt = '0;
        s_next.pos = pos_in;
        s_next.pos_stb = 1'b1;
      end else begin
        s_next.pos_cnt = s_reg.pos_cnt + 3'h1;
      end
    end
    // wake timers run in every wake state; ms and inactivity counts saturate, calibration count wraps
    if (s_reg.st != ST_PROC) begin
      if (s_reg.ms_tk && s_reg.app_cnt != 8'hFF) begin
        s_next.app_cnt = s_reg.app_cnt + 8'h01;
      end
      if (s_reg.sec_tk) begin
        s_next.cal_cnt = s_reg.cal_cnt + 11'h001;
        if (s_reg.inact != 10'h3FF) begin
          s_next.inact = s_reg.inact + 10'h001;
        end
        if (s_reg.inact >= s_reg.trans) begin
          s_next.fin_sel = 1'b1;
        end
      end
    end
    cal_lim = s_reg.fin_sel ? s_reg.cal_fin : s_reg.cal_st;
    for (int c = 0; c < NCH; c++) begin
      over = over | (s_reg.chmsk[c] && ch_delta[c] > s_reg.thr);
    end
    // scheduler
    case (s_reg.st)
      ST_PROC: s_next.rx_en = 5'h1F; // all channels while processing
      ST_SLEEP: begin
        s_next.rx_en = 5'h00;
        s_next.scn = '0;
        // calibration takes the slot when both are due
        if (s_reg.cal_cnt >= cal_lim) begin
          s_next.st = ST_CAL;
          s_next.cal_cnt = '0;
          s_next.rx_en = 5'h1F;
        end else if (s_reg.app_cnt >= s_reg.app_ms) begin
          s_next.st = ST_APP;
          s_next.app_cnt = '0;
          s_next.rx_en = s_reg.chmsk;
        end
      end
      ST_APP: begin
        s_next.scn = s_reg.scn + 4'h1;
        if (s_reg.scn == 4'(SCAN_CYC - 1)) begin
          if (over) begin
            s_next.st = ST_PROC;
            s_next.rx_en = 5'h1F;
            ev[EV_APPR] = 1'b1;
          end else begin
            s_next.st = ST_SLEEP;
            s_next.rx_en = 5'h00;
          end
        end
      end
      ST_CAL: begin
        s_next.scn = s_reg.scn + 4'h1;
        if (s_reg.scn == 4'(SCAN_CYC - 1)) begin
          s_next.st = ST_SLEEP;
          s_next.rx_en = 5'h00;
        end
      end
      default: s_next.st = ST_PROC;
    endcase
    // apb: answer one cycle after setup
    s_next.pready = psel && !penable;
    if (psel && !penable) begin
      s_next.pslverr = 1'b0;
      s_next.prdata = '0;
      case (paddr)
        OFF_CTRL: s_next.prdata = {31'h0, s_reg.st != ST_PROC};
        OFF_STAT: s_next.prdata = {24'h0, s_reg.stat | ev}; // setup-cycle event is not lost
        OFF_MASK: s_next.prdata = {24'h0, s_reg.mask};
        OFF_MAP0: s_next.prdata = s_reg.map0;
        OFF_MAP1: s_next.prdata = s_reg.map1;
        OFF_TAP: s_next.prdata = {6'h0, s_reg.dtap_ms, 6'h0, s_reg.tap_ms};
        OFF_TOUCH: s_next.prdata = {11'h0, core.touch, 6'h0, s_reg.long_ms};
        OFF_SCAN: s_next.prdata = {4'h0, s_reg.thr, 3'h0, s_reg.chmsk, s_reg.app_ms};
        OFF_CAL: s_next.prdata = {s_reg.trans, s_reg.cal_fin, s_reg.cal_st};
        OFF_WHEEL: s_next.prdata = {16'h0, s_reg.wheel};
        default: s_next.pslverr = 1'b1; // unmapped
      endcase
    end else if (s_reg.pready) begin
      s_next.pslverr = 1'b0;
    end
    if (wr && !s_reg.pslverr) begin
      case (paddr)
        OFF_CTRL: begin
          // entering wake-up restarts all wake timers
          if (pwdata[0] && s_reg.st == ST_PROC) begin
            s_next.st = ST_SLEEP;
            s_next.rx_en = 5'h00;
            s_next.app_cnt = '0;
            s_next.cal_cnt = '0;
            s_next.inact = '0;
            s_next.fin_sel = 1'b0;
            s_next.sec_div = '0; // first interval is a full one
            s_next.sec_tk = 1'b0;
          end
        end
        OFF_MASK: s_next.mask = pwdata[7:0];
        OFF_MAP0: s_next.map0 = pwdata;
        OFF_MAP1: s_next.map1 = pwdata;
        OFF_TAP: begin
          s_next.tap_ms = pwdata[9:0];
          s_next.dtap_ms = pwdata[25:16];
        end
        OFF_TOUCH: s_next.long_ms = pwdata[9:0];
        OFF_SCAN: begin
          s_next.app_ms = pwdata[7:0];
          s_next.chmsk = pwdata[12:8];
          s_next.thr = pwdata[27:16];
        end
        OFF_CAL: begin
          s_next.cal_st = pwdata[10:0];
          s_next.cal_fin = pwdata[21:11];
          s_next.trans = pwdata[31:22];
        end
        default: ;
      endcase
    end
    // read clears status, a new event in the same cycle survives
    if (rd && paddr == OFF_STAT) begin
      s_next.stat = ev;
    end else begin
      s_next.stat = s_reg.stat | ev;
    end
    s_next.irq = |(s_next.stat & s_next.mask);
    lev = ev; // level view for the level pin actions
    lev[EV_TOUCH] = |s_reg.tprev;
  end

  // route each event to its pin with its action
  always_comb begin
    logic [63:0] mp;
    logic [2:0] pn, ac;
    mp = {s_reg.map1, s_reg.map0};
    pn = '0;
    ac = '0;
    p_hi = '0;
    p_lo = '0;
    p_tog = '0;
    p_pls = '0;
    p_len = '0;
    p_lvl = '0;
    for (int e = 0; e < NEV; e++) begin
      pn = mp[8*e +: 3];
      ac = mp[8*e+3 +: 3];
      for (int p = 0; p < NPIN; p++) begin
        if (pn == 3'(p)) begin
          p_hi[p] = p_hi[p] | (ac == ACT_HI && ev[e]);
          p_lo[p] = p_lo[p] | (ac == ACT_LO && ev[e]);
          p_tog[p] = p_tog[p] | (ac == ACT_TOG && ev[e]);
          p_pls[p] = p_pls[p] | (ac == ACT_PLS && ev[e]);
          p_len[p] = p_len[p] | (ac == ACT_LVH) | (ac == ACT_LVL);
          p_lvl[p] = p_lvl[p] | (ac == ACT_LVH && lev[e]) | (ac == ACT_LVL && !lev[e]);
        end
      end
    end
  end

  // five pin engines
  for (genvar g = 0; g < NPIN; g++) begin : g_pin
    gep_pin u_pin (
      .pclk(pclk),
      .presetn(presetn),
      .ms_tk(s_reg.ms_tk),
      .set_hi(p_hi[g]),
      .set_lo(p_lo[g]),
      .tog(p_tog[g]),
      .pls(p_pls[g]),
      .lvl_en(p_len[g]),
      .lvl(p_lvl[g]),
      .pin(event_output_pin[g])
    );
  end

  // state register; control fields take their reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= ST_PROC;
      s_reg.rx_en <= 5'h1F;
      s_reg.map0 <= RST_MAP;
      s_reg.map1 <= RST_MAP;
      s_reg.tap_ms <= RST_TAP_MS;
      s_reg.dtap_ms <= RST_DTAP_MS;
      s_reg.long_ms <= RST_LONG_MS;
      s_reg.app_ms <= RST_APP_MS;
      s_reg.chmsk <= RST_CHMSK;
      s_reg.thr <= RST_THR;
      s_reg.cal_st <= RST_CAL_ST;
      s_reg.cal_fin <= RST_CAL_FIN;
      s_reg.trans <= RST_TRANS;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign pos_out = s_reg.pos;
  assign pos_stb = s_reg.pos_stb;
  assign rx_en = s_reg.rx_en;
  assign proc_mode = s_reg.st[0];
  assign irq = s_reg.irq;
endmodule
`default_nettype wire

// [testbench/gep_top_sva.sv]
// checker: port-level properties of the gesture event port
`default_nettype none
module gep_top_sva
  import gep_pkg::*;
#(
  parameter int MS_DIV = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pos_stb,
  input wire logic [4:0] rx_en,
  input wire logic proc_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  // one domain: clock and reset given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // every transfer answers in its first access cycle
  property p_rdy;
    psel && !penable |=> pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no pready after setup");
  property p_rdy1;
    pready |=> !pready;
  endproperty
  a_rdy1: assert property (p_rdy1) else $error("pready longer than one cycle");
  // aligned offsets past the map answer with an error
  property p_err;
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h24);
  endproperty
  a_err: assert property (p_err) else $error("pslverr wrong for offset");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  // processing keeps all channels on
  property p_proc_rx;
    proc_mode |-> rx_en == 5'h1F;
  endproperty
  a_proc_rx: assert property (p_proc_rx) else $error("channels off in processing");
  // a scan phase is never cut short
  property p_scan;
    !proc_mode && $rose(|rx_en) |-> (|rx_en) [*8];
  endproperty
  a_scan: assert property (p_scan) else $error("scan shorter than eight cycles");
  // wake only from a scan, never straight out of sleep
  property p_wake;
    $rose(proc_mode) |-> $past(rx_en) != 5'h00;
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside a scan");
  // self wake-up opens with a sleep phase
  property p_sleep;
    $fell(proc_mode) |-> rx_en == 5'h00;
  endproperty
  a_sleep: assert property (p_sleep) else $error("wake-up did not start asleep");
  // samples are ms apart, far more than eight cycles
  property p_pos;
    pos_stb |=> !pos_stb [*8];
  endproperty
  a_pos: assert property (p_pos) else $error("position strobes too close");
  c_err: cover property (pslverr);
  c_wake: cover property ($rose(proc_mode));
  c_cal: cover property (!proc_mode && rx_en == 5'h1F);
endmodule
bind gep_top gep_top_sva #(.MS_DIV(MS_DIV)) u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .pos_stb(pos_stb), .rx_en(rx_en), .proc_mode(proc_mode));
`default_nettype wire

// [testbench/gep_pin_mon.sv]
// pin watcher standing in for the logic that listens to the event pins
`default_nettype none
module gep_pin_mon (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [4:0] pins,
  output logic [4:0][7:0] rises,
  output logic [4:0][15:0] hlen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] prev_reg; // last sampled level
  logic [4:0][15:0] cnt_reg; // high time so far
  // edge counter and high-time meter per pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= '0;
      cnt_reg <= '0;
      rises <= '0;
      hlen <= '0;
    end else begin
      prev_reg <= pins;
      for (int i = 0; i < 5; i++) begin
        cnt_reg[i] <= pins[i] ? cnt_reg[i] + 16'h0001 : 16'h0000;
        if (pins[i] && !prev_reg[i]) rises[i] <= rises[i] + 8'h01;
        // a level still held is not timed yet
        if (!pins[i] && prev_reg[i]) hlen[i] <= cnt_reg[i];
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/test_gep_top.sv]
// testbench: scenario tasks for the gesture event port
`default_nettype none
module test_gep_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gep_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, pos_stb, proc_mode, irq;
  gep_core_t core = '0;
  gep_pos_t pos_in = 48'h000300020001; // fixed sample
  logic [4:0][11:0] ch_delta = '0;
  logic [4:0] pins, rx_en;
  gep_pos_t pos_out;
  logic [4:0][7:0] rises;
  logic [4:0][15:0] hlen;
  logic [31:0] rv; // last read data
  logic re; // last error flag
  int bad_count = 0;
  int n_compared = 0;
  always #4 pclk = ~pclk;
  // tick of 4 cycles keeps the ms timers short
  gep_top #(.MS_DIV(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core(core), .pos_in(pos_in),
    .ch_delta(ch_delta), .event_output_pin(pins), .pos_out(pos_out), .pos_stb(pos_stb),
    .rx_en(rx_en), .proc_mode(proc_mode), .irq(irq));
  gep_pin_mon u_mon (.pclk(pclk), .presetn(presetn), .pins(pins), .rises(rises),
    .hlen(hlen));
  task summarize;
    if (bad_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // a spent bound counts as a mismatch and ends the run
  task lim(input int k, input int n);
    if (k >= n) begin
      bad_count++;
      summarize();
    end
  endtask
  // one apb transfer; an idle edge first so psel is never set twice at once
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    lim(k, 50);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rv, e);
  endtask
  task touch(input int e, input int n);
    core.touch[e] <= 1'b1;
    cyc(n);
    core.touch[e] <= 1'b0;
    cyc(20);
  endtask
  task whl(input logic cw, input int n);
    repeat (n) begin
      core.whl_step <= 1'b1;
      core.whl_cw <= cw;
      cyc(1);
      core.whl_step <= 1'b0;
      cyc(1);
    end
  endtask
  // result must wait for the end of the movement
  task circ(input logic cw);
    core.circ_det <= 1'b1;
    core.circ_cw <= cw;
    cyc(1);
    core.circ_det <= 1'b0;
    cyc(6);
    chk(pins[3], !cw);
    core.circ_end <= 1'b1;
    cyc(1);
    core.circ_end <= 1'b0;
    cyc(3);
    chk(pins[3], cw);
    rd(OFF_STAT, cw ? 32'h00000020 : 32'h00000040);
  endtask
  task t_regs;
    rd(OFF_MASK, 32'h00000000);
    rd(OFF_MAP1, RST_MAP);
    rd(OFF_TAP, {6'h00, RST_DTAP_MS, 6'h00, RST_TAP_MS});
    rd(OFF_SCAN, {4'h0, RST_THR, 3'h0, RST_CHMSK, RST_APP_MS});
    rd(OFF_CAL, {RST_TRANS, RST_CAL_FIN, RST_CAL_ST});
    apb(1'b0, 8'h40, 32'h00000000);
    chk(re, 1'b1);
    apb(1'b1, OFF_STAT, 32'h000000FF);
    rd(OFF_STAT, 32'h00000000);
  endtask
  // zero tap delay: a long touch yields no tap
  task t_long;
    apb(1'b1, OFF_TAP, 32'h01F40000);
    apb(1'b1, OFF_TOUCH, 32'h00000002);
    touch(0, 40);
    rd(OFF_STAT, 32'h00000018);
  endtask
  task t_tap;
    apb(1'b1, OFF_TAP, 32'h01F401F4);
    apb(1'b1, OFF_TOUCH, 32'h000001F4);
    apb(1'b1, OFF_MAP0, 32'hFFFF1910);
    core.touch[3] <= 1'b1;
    rd(OFF_TOUCH, 32'h000801F4);
    core.touch[3] <= 1'b0;
    cyc(20);
    touch(3, 12);
    cyc(450);
    chk(hlen[1] >= 16'd396 && hlen[1] <= 16'd404, 1'b1);
    chk({rises[0], 7'h00, pins[0]}, 16'h0100);
    chk(irq, 1'b0);
    apb(1'b1, OFF_MASK, 32'h00000001);
    cyc(2);
    chk(irq, 1'b1);
    rd(OFF_STAT, 32'h00000017);
    cyc(2);
    chk(irq, 1'b0);
  endtask
  task t_circ;
    apb(1'b1, OFF_MAP1, 32'h1C0B0322);
    core.touch[1] <= 1'b1;
    cyc(4);
    chk(pins[2], 1'b1);
    core.touch[1] <= 1'b0;
    cyc(4);
    chk(pins[2], 1'b0);
    apb(1'b0, OFF_STAT, 32'h00000000);
    circ(1'b1);
    circ(1'b0);
    whl(1'b1, 3);
    whl(1'b0, 1);
    rd(OFF_WHEEL, 32'h00000002);
    whl(1'b0, 3);
    rd(OFF_WHEEL, 32'h0000FFFF);
  endtask
  task t_pos;
    int k;
    k = 0;
    while (pos_stb !== 1'b1 && k < 60) begin
      cyc(1);
      k++;
    end
    lim(k, 60);
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (pos_stb !== 1'b1 && k < 60);
    chk(k, 20);
    chk(pos_out[31:0], pos_in[31:0]);
    chk(pos_out[47:32], pos_in[47:32]);
  endtask
  // equal delta must not wake; one count above must
  task t_wake;
    int k;
    apb(1'b1, OFF_SCAN, 32'h00400314);
    ch_delta[1] <= 12'h040;
    apb(1'b1, OFF_CTRL, 32'h00000001);
    cyc(1);
    chk(proc_mode, 1'b0);
    rd(OFF_CTRL, 32'h00000001);
    k = 0;
    while (rx_en !== 5'h03 && k < 300) begin
      cyc(1);
      k++;
    end
    lim(k, 300);
    k = 0;
    while (rx_en !== 5'h1F && k < 9000) begin
      cyc(1);
      k++;
    end
    lim(k, 9000);
    chk(k > 7700, 1'b1);
    chk(proc_mode, 1'b0);
    ch_delta[1] <= 12'h041;
    apb(1'b1, OFF_MASK, 32'h00000080);
    k = 0;
    while (proc_mode !== 1'b1 && k < 300) begin
      cyc(1);
      k++;
    end
    lim(k, 300);
    cyc(2);
    chk(irq, 1'b1);
    chk({rises[4], pins[4]}, 9'h003);
    rd(OFF_STAT, 32'h00000080);
  endtask
  initial begin
    cyc(20);
    presetn <= 1'b1;
    t_regs();
    t_long();
    t_tap();
    t_circ();
    t_pos();
    t_wake();
    summarize();
  end
endmodule
`default_nettype wire
